// [hw/mftam_pkg.sv]
// package: fault supervision constants, register map and carrier types
package mftam_pkg;

   // register byte offsets
   localparam logic [7:0] MFTAM_OFS_CTRL     = 8'h00;
   localparam logic [7:0] MFTAM_OFS_STATUS   = 8'h04;
   localparam logic [7:0] MFTAM_OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] MFTAM_OFS_IRQ_MASK = 8'h0c;
   localparam logic [7:0] MFTAM_OFS_CMD      = 8'h10;

   // control field positions
   localparam int MFTAM_CTRL_AUTORESET  = 0;
   localparam int MFTAM_CTRL_EMERGENCY  = 1;
   localparam int MFTAM_CTRL_TOVL_TRIP  = 2;
   localparam int MFTAM_CTRL_TSHT_TRIP  = 3;
   localparam int MFTAM_CTRL_SUBST_MODE = 4;
   localparam int MFTAM_CTRL_SUBST_VAL  = 5;
   localparam int MFTAM_CTRL_W          = 6;
   localparam int MFTAM_CMD_TRIP_RESET  = 0;

   // values after reset
   localparam logic [5:0]  MFTAM_CTRL_RST = 6'h00;
   localparam logic [10:0] MFTAM_MASK_RST = 11'h000;

   // trip latch indices
   localparam int MFTAM_FI_PIE  = 0;
   localparam int MFTAM_FI_DEF  = 1;
   localparam int MFTAM_FI_UVN  = 2;
   localparam int MFTAM_FI_UVS  = 3;
   localparam int MFTAM_FI_SENS = 4;
   localparam int MFTAM_FI_TOVL = 5;
   localparam int MFTAM_FI_TSHT = 6;
   localparam int MFTAM_N_FAULT = 7;

   // signalling bits towards the bus master, also the irq layout
   typedef struct packed {
      logic master_stop;
      logic bus_fault;
      logic temp_short;
      logic temp_ovl;
      logic ovl_trip;
      logic sensor_ovl;
      logic elec_uv;
      logic defect;
      logic pie;
      logic gen_warn;
      logic gen_fault;
   } mftam_status_t;

   localparam int MFTAM_STATUS_W = $bits(mftam_status_t);

   // sensed fault causes
   typedef struct packed {
      logic pie;
      logic defect;
      logic unswitched_supply_rail_low;
      logic switched_supply_rail_low;
      logic sensor_ovl;
      logic temp_ovl;
      logic temp_short;
   } mftam_cause_t;

endpackage : mftam_pkg

// [hw/mftam_edge.sv]
// rising edge detector for the trip-reset level
`timescale 1ns/1ps
module mftam_edge (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic srst_i,
   // level in, pulse out
   input  wire logic level_i,
   output logic      pulse_o
);
   logic prev_reg;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= level_i;
      end
   end

   assign pulse_o = level_i & ~prev_reg;
endmodule : mftam_edge

// [hw/mftam_trip_cell.sv]
// one latched trip: set by its cause, cleared by an acknowledge once the cause is gone
`timescale 1ns/1ps
module mftam_trip_cell (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic srst_i,
   // cause and acknowledge
   input  wire logic cause_i,
   input  wire logic trip_en_i,
   input  wire logic ack_i,
   // latched trip
   output logic      trip_o
);
   logic trip_reg;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         trip_reg <= 1'b0;
      end else if (cause_i && trip_en_i) begin
         trip_reg <= 1'b1;
      end else if (ack_i && !cause_i) begin
         trip_reg <= 1'b0;
      end
   end

   assign trip_o = trip_reg;
endmodule : mftam_trip_cell

// [hw/mftam_top.sv]
// fault supervision, trip latching and acknowledgement for a bus-controlled motor starter
//
// Behaviour
// - process image error and switching element defect always trip, never warn.
// - every system fault except switched-supply undervoltage sets its signalling bit in the cyclic status word.
// - after a trip the switch stays off until cause gone and acknowledged.
// - emergency start lets commands switch despite general fault, not device fault.
// - trip-reset bit or trip-reset command both acknowledge faults.
// - autoreset acknowledges temperature trips automatically once the cause has cleared.
// - image error sets fault bits, lights fault red, cleared only by run withdrawal.
// - trip-reset acts on rising edge; held high acknowledges once.
// - bus loss sets bus-fault, lights bus indicator, applies substitute or last.
// - master stop sets its bit, bus indicator off, substitute or last.
// - supply under 18 V trips; unswitched also flags undervoltage, auto-acknowledged.
// - sensor supply overload trips, fault red, cleared only by trip-reset.
// - temperature overload warns and auto-clears, or trips needing autoreset/trip-reset.
// - temperature-overload trip acknowledgement refused while motor still hot.
// - temperature short-circuit handled like overload, with its own bit.
// - auto-acknowledged faults clear when cause disappears, whatever the autoreset setting.
`timescale 1ns/1ps
module mftam_top
   import mftam_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 32
) (
   // clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      srst_i,
   // register port
   input  wire logic [ADDR_W-1:0]         addr_i,
   input  wire logic [DATA_W-1:0]         wdata_i,
   input  wire logic                      wr_i,
   input  wire logic                      rd_i,
   output logic [DATA_W-1:0]              rdata_o,
   // cyclic output image from the master
   input  wire logic                      run_cmd_i,
   input  wire logic                      trip_reset_bit_i,
   input  wire logic                      bus_comm_ok_i,
   input  wire logic                      master_run_i,
   // fault detectors
   input  wire mftam_pkg::mftam_cause_t   cause_i,
   // switching element and indicators
   output logic                           switch_on_o,
   output logic                           system_fault_indicator_o,
   output logic                           bus_fault_indicator_o,
   // cyclic input image to the master
   output mftam_pkg::mftam_status_t       status_o,
   // interrupt
   output logic                           irq_o
);
   import mftam_pkg::*;

   // the map decodes the low eight address bits and returns an 11-bit status
   if (ADDR_W < 8 || DATA_W < MFTAM_STATUS_W) begin : g_chk
      $error("mftam_top: ADDR_W must be >= 8 and DATA_W >= status width");
   end

   // control and software state
   logic [MFTAM_CTRL_W-1:0]     ctrl_reg;
   logic [MFTAM_STATUS_W-1:0]   irq_stat_reg;
   logic [MFTAM_STATUS_W-1:0]   irq_stat_next;
   logic [MFTAM_STATUS_W-1:0]   irq_mask_reg;
   logic [DATA_W-1:0]           rdata_reg;
   logic                        cmd_reset_reg;
   logic                        last_run_reg;
   logic                        switch_on_reg;
   logic                        fault_ind_reg;
   logic                        bus_ind_reg;
   logic                        irq_reg;
   mftam_status_t               status_reg;
   mftam_status_t               status_next;

   // decode
   logic [7:0]                  ofs;
   logic                        wr_ctrl;
   logic                        wr_mask;
   logic                        wr_cmd;
   logic                        rd_irq;

   // acknowledge and trip state
   logic                        edge_pulse;
   logic                        ack_pulse;
   logic                        autoreset;
   logic                        emergency;
   logic [MFTAM_N_FAULT-1:0]    cause_vec;
   logic [MFTAM_N_FAULT-1:0]    trip_en_vec;
   logic [MFTAM_N_FAULT-1:0]    ack_vec;
   logic [MFTAM_N_FAULT-1:0]    trip_vec;
   logic                        gen_fault;
   logic                        device_fault;
   logic                        bus_fault;
   logic                        master_stop;
   logic                        eff_run;
   logic                        switch_on_next;

   assign ofs     = addr_i[7:0];
   assign wr_ctrl = wr_i && (ofs == MFTAM_OFS_CTRL);
   assign wr_mask = wr_i && (ofs == MFTAM_OFS_IRQ_MASK);
   assign wr_cmd  = wr_i && (ofs == MFTAM_OFS_CMD);
   assign rd_irq  = rd_i && (ofs == MFTAM_OFS_IRQ_STAT);

   assign autoreset = ctrl_reg[MFTAM_CTRL_AUTORESET];
   assign emergency = ctrl_reg[MFTAM_CTRL_EMERGENCY];

   // control register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctrl_reg <= MFTAM_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_reg <= wdata_i[MFTAM_CTRL_W-1:0];
      end
   end

   // interrupt mask register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_mask_reg <= MFTAM_MASK_RST;
      end else if (wr_mask) begin
         irq_mask_reg <= wdata_i[MFTAM_STATUS_W-1:0];
      end
   end

   // trip-reset command is a one-cycle event of its own; a write is already an edge
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cmd_reset_reg <= 1'b0;
      end else begin
         cmd_reset_reg <= wr_cmd && wdata_i[MFTAM_CMD_TRIP_RESET];
      end
   end

   mftam_edge u_edge (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .level_i (trip_reset_bit_i),
      .pulse_o (edge_pulse)
   );

   assign ack_pulse = edge_pulse | cmd_reset_reg;

   assign cause_vec[MFTAM_FI_PIE]  = cause_i.pie;
   assign cause_vec[MFTAM_FI_DEF]  = cause_i.defect;
   assign cause_vec[MFTAM_FI_UVN]  = cause_i.unswitched_supply_rail_low;
   assign cause_vec[MFTAM_FI_UVS]  = cause_i.switched_supply_rail_low;
   assign cause_vec[MFTAM_FI_SENS] = cause_i.sensor_ovl;
   assign cause_vec[MFTAM_FI_TOVL] = cause_i.temp_ovl;
   assign cause_vec[MFTAM_FI_TSHT] = cause_i.temp_short;

   assign trip_en_vec[MFTAM_FI_PIE]  = 1'b1;
   assign trip_en_vec[MFTAM_FI_DEF]  = 1'b1;
   assign trip_en_vec[MFTAM_FI_UVN]  = 1'b1;
   assign trip_en_vec[MFTAM_FI_UVS]  = 1'b1;
   assign trip_en_vec[MFTAM_FI_SENS] = 1'b1;
   assign trip_en_vec[MFTAM_FI_TOVL] = ctrl_reg[MFTAM_CTRL_TOVL_TRIP];
   assign trip_en_vec[MFTAM_FI_TSHT] = ctrl_reg[MFTAM_CTRL_TSHT_TRIP];

   // countercommand clears image error; a dead link carries none
   assign ack_vec[MFTAM_FI_PIE]  = ~run_cmd_i & ~bus_fault;
   // device defect only clears on reset
   assign ack_vec[MFTAM_FI_DEF]  = 1'b0;
   assign ack_vec[MFTAM_FI_UVN]  = 1'b1;
   assign ack_vec[MFTAM_FI_UVS]  = 1'b1;
   assign ack_vec[MFTAM_FI_SENS] = ack_pulse;
   assign ack_vec[MFTAM_FI_TOVL] = ack_pulse | autoreset;
   assign ack_vec[MFTAM_FI_TSHT] = ack_pulse | autoreset;

   // cell refuses ack while cause stands
   for (genvar gi = 0; gi < MFTAM_N_FAULT; gi++) begin : g_trip
      mftam_trip_cell u_cell (
         .clk_i     (clk_i),
         .srst_i    (srst_i),
         .cause_i   (cause_vec[gi]),
         .trip_en_i (trip_en_vec[gi]),
         .ack_i     (ack_vec[gi]),
         .trip_o    (trip_vec[gi])
      );
   end

   assign gen_fault    = |trip_vec;
   assign device_fault = trip_vec[MFTAM_FI_DEF];
   assign bus_fault    = ~bus_comm_ok_i;
   assign master_stop  = bus_comm_ok_i & ~master_run_i;

   always_comb begin
      status_next             = '0;
      status_next.gen_fault   = gen_fault;
      status_next.pie         = trip_vec[MFTAM_FI_PIE];
      status_next.defect      = trip_vec[MFTAM_FI_DEF];
      status_next.elec_uv     = trip_vec[MFTAM_FI_UVN];
      status_next.sensor_ovl  = trip_vec[MFTAM_FI_SENS];
      status_next.ovl_trip    = trip_vec[MFTAM_FI_TOVL] | trip_vec[MFTAM_FI_TSHT];
      status_next.temp_ovl    = trip_vec[MFTAM_FI_TOVL] |
                                (cause_i.temp_ovl & ~ctrl_reg[MFTAM_CTRL_TOVL_TRIP]);
      status_next.temp_short  = trip_vec[MFTAM_FI_TSHT] |
                                (cause_i.temp_short & ~ctrl_reg[MFTAM_CTRL_TSHT_TRIP]);
      status_next.gen_warn    =
         (cause_i.temp_ovl & ~ctrl_reg[MFTAM_CTRL_TOVL_TRIP]) |
         (cause_i.temp_short & ~ctrl_reg[MFTAM_CTRL_TSHT_TRIP]);
      status_next.bus_fault   = bus_fault;
      status_next.master_stop = master_stop;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         status_reg <= '0;
      end else begin
         status_reg <= status_next;
      end
   end

   // last value is frozen at the moment the link stops serving run commands
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         last_run_reg <= 1'b0;
      end else if (!bus_fault && !master_stop) begin
         last_run_reg <= run_cmd_i;
      end
   end

   always_comb begin
      if (bus_fault || master_stop) begin
         if (ctrl_reg[MFTAM_CTRL_SUBST_MODE]) begin
            eff_run = ctrl_reg[MFTAM_CTRL_SUBST_VAL];
         end else begin
            eff_run = last_run_reg;
         end
      end else begin
         eff_run = run_cmd_i;
      end
   end

   always_comb begin
      if (!gen_fault) begin
         switch_on_next = eff_run;
      end else if (emergency && !device_fault) begin
         switch_on_next = eff_run;
      end else begin
         switch_on_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         switch_on_reg <= 1'b0;
      end else begin
         switch_on_reg <= switch_on_next;
      end
   end

   // fault indicator red on any trip
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fault_ind_reg <= 1'b0;
      end else begin
         fault_ind_reg <= gen_fault;
      end
   end

   // bus indicator only on real loss
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bus_ind_reg <= 1'b0;
      end else begin
         bus_ind_reg <= bus_fault;
      end
   end

   // new events set sticky bits; set wins over the clear-on-read
   always_comb begin
      irq_stat_next = irq_stat_reg;
      if (rd_irq) begin
         irq_stat_next = '0;
      end
      irq_stat_next = irq_stat_next | (status_next & ~status_reg);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_stat_reg <= '0;
      end else begin
         irq_stat_reg <= irq_stat_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_stat_next & irq_mask_reg);
      end
   end

   // read data for one cycle only; unmapped and write-only offsets read zero
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_reg <= '0;
      end else if (rd_i) begin
         case (ofs)
            MFTAM_OFS_CTRL: begin
               rdata_reg <= DATA_W'(ctrl_reg);
            end
            MFTAM_OFS_STATUS: begin
               rdata_reg <= DATA_W'(status_reg);
            end
            MFTAM_OFS_IRQ_STAT: begin
               rdata_reg <= DATA_W'(irq_stat_reg);
            end
            MFTAM_OFS_IRQ_MASK: begin
               rdata_reg <= DATA_W'(irq_mask_reg);
            end
            default: begin
               rdata_reg <= '0;
            end
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end

   assign rdata_o                  = rdata_reg;
   assign switch_on_o              = switch_on_reg;
   assign system_fault_indicator_o = fault_ind_reg;
   assign bus_fault_indicator_o    = bus_ind_reg;
   assign status_o                 = status_reg;
   assign irq_o                    = irq_reg;
endmodule : mftam_top

// [testbench/mftam_checker.sv]
// checker: port-level assertions for the fault manager
`timescale 1ns/1ps
module mftam_checker
   import mftam_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 32
) (
   // clock and reset
   input wire logic                clk_i,
   input wire logic                srst_i,
   // register port
   input wire logic [ADDR_W-1:0]   addr_i,
   input wire logic [DATA_W-1:0]   wdata_i,
   input wire logic                wr_i,
   input wire logic                rd_i,
   input wire logic [DATA_W-1:0]   rdata_o,
   // cyclic image and causes
   input wire logic                run_cmd_i,
   input wire logic                trip_reset_bit_i,
   input wire logic                bus_comm_ok_i,
   input wire logic                master_run_i,
   input wire mftam_cause_t        cause_i,
   // outputs
   input wire logic                switch_on_o,
   input wire logic                system_fault_indicator_o,
   input wire logic                bus_fault_indicator_o,
   input wire mftam_status_t       status_o,
   input wire logic                irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   property p_pie;
      cause_i.pie |-> ##2 status_o.gen_fault && status_o.pie;
   endproperty
   a_pie: assert property (p_pie) else $error("image error not tripped");
   property p_defect;
      cause_i.defect |-> ##2 (!switch_on_o && status_o.defect)[*4];
   endproperty
   a_defect: assert property (p_defect) else $error("defect not holding off");
   property p_sf;
      status_o.gen_fault == system_fault_indicator_o;
   endproperty
   a_sf: assert property (p_sf) else $error("fault indicator differs");
   property p_rd_status;
      rd_i && addr_i[7:0] == MFTAM_OFS_STATUS |=>
         rdata_o[MFTAM_STATUS_W-1:0] == $past(status_o);
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("status read wrong");
   property p_rd_idle;
      !rd_i |=> rdata_o == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
   property p_bus_led;
      !$past(srst_i) |-> bus_fault_indicator_o == !$past(bus_comm_ok_i);
   endproperty
   a_bus_led: assert property (p_bus_led) else $error("bus indicator wrong");
   property p_stop;
      bus_comm_ok_i && !master_run_i |->
         ##1 !bus_fault_indicator_o ##[0:1] status_o.master_stop;
   endproperty
   a_stop: assert property (p_stop) else $error("master stop wrong");
   property p_uv;
      cause_i.unswitched_supply_rail_low |-> ##2 status_o.elec_uv && status_o.gen_fault;
   endproperty
   a_uv: assert property (p_uv) else $error("undervoltage not tripped");
   property p_uv_clear;
      (!cause_i.unswitched_supply_rail_low)[*5] |-> !status_o.elec_uv;
   endproperty
   a_uv_clear: assert property (p_uv_clear) else $error("undervoltage stuck");
   property p_tovl;
      cause_i.temp_ovl |-> ##[1:2] status_o.temp_ovl;
   endproperty
   a_tovl: assert property (p_tovl) else $error("overload bit missing");
   // only an acknowledge may drop a sensor trip
   property p_sens_ack;
      $fell(status_o.sensor_ovl) && !$past(srst_i) |->
         ($past(trip_reset_bit_i, 2) && !$past(trip_reset_bit_i, 3)) ||
         ($past(wr_i, 3) && $past(wdata_i[0], 3) && $past(addr_i[7:0], 3) == MFTAM_OFS_CMD);
   endproperty
   a_sens_ack: assert property (p_sens_ack) else $error("sensor trip dropped");
endmodule : mftam_checker

bind mftam_top mftam_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_inst (
   .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .run_cmd_i(run_cmd_i),
   .trip_reset_bit_i(trip_reset_bit_i), .bus_comm_ok_i(bus_comm_ok_i),
   .master_run_i(master_run_i), .cause_i(cause_i), .switch_on_o(switch_on_o),
   .system_fault_indicator_o(system_fault_indicator_o),
   .bus_fault_indicator_o(bus_fault_indicator_o), .status_o(status_o), .irq_o(irq_o));

// [testbench/mftam_master_model.sv]
// partner model: field bus master driving the cyclic output image
`timescale 1ns/1ps
module mftam_master_model (
   // clock
   input  wire logic clk_i,
   // cyclic output image
   output logic      run_cmd_o,
   output logic      trip_reset_bit_o,
   output logic      bus_comm_ok_o,
   output logic      master_run_o
);
   logic run_reg  = 1'b0;
   logic trb_reg  = 1'b0;
   logic ok_reg   = 1'b1;
   logic mrun_reg = 1'b1;
   // run withdrawal as countercommand; a dead link shows junk
   assign run_cmd_o        = ok_reg ? run_reg : ~run_reg;
   assign trip_reset_bit_o = trb_reg;
   assign bus_comm_ok_o    = ok_reg;
   assign master_run_o     = mrun_reg;
   task automatic image(input logic run, input logic trb, input logic ok, input logic mrun);
      @(posedge clk_i);
      run_reg  <= run;
      trb_reg  <= trb;
      ok_reg   <= ok;
      mrun_reg <= mrun;
   endtask : image
endmodule : mftam_master_model

// [testbench/testbench.sv]
// testbench: register access and fault scenarios for the fault manager
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
   $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module testbench;
   import mftam_pkg::*;
   logic          clk_i   = 1'b0;
   logic          srst_i  = 1'b1;
   logic [7:0]    addr_i  = 8'h00;
   logic [31:0]   wdata_i = 32'h0;
   logic          wr_i    = 1'b0;
   logic          rd_i    = 1'b0;
   mftam_cause_t  cause_i = '0;
   logic [31:0]   rdata_o, d;
   logic          run, trb, ok, mrun, sw_o, fault_ind_o, bus_ind_o, irq_o;
   mftam_status_t status_o;
   int            failures = 0;
   int            checks_done = 0;
   int            cycles = 0;

   always #12.5 clk_i = ~clk_i;

   mftam_master_model master_model_inst (.clk_i(clk_i), .run_cmd_o(run),
      .trip_reset_bit_o(trb), .bus_comm_ok_o(ok), .master_run_o(mrun));
   mftam_top mftam_top_inst (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .run_cmd_i(run),
      .trip_reset_bit_i(trb), .bus_comm_ok_i(ok), .master_run_i(mrun), .cause_i(cause_i),
      .switch_on_o(sw_o), .system_fault_indicator_o(fault_ind_o),
      .bus_fault_indicator_o(bus_ind_o),
      .status_o(status_o), .irq_o(irq_o));

   task automatic close_out;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   // a hang ends the run as a failure
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         $display("mismatch at %0t: timeout", $time);
         failures++;
         close_out();
      end
   end

   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask : wt
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      @(negedge clk_i);
      v = rdata_o;
   endtask : rd_reg
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      rd_reg(a, d);
      `CHK(d, e)
   endtask : rd_chk
   task automatic cz(input mftam_cause_t c);
      @(posedge clk_i);
      cause_i <= c;
   endtask : cz
   task automatic st(input logic [10:0] e, input logic sw);
      `CHK(status_o, e)
      `CHK(sw_o, sw)
      `CHK(fault_ind_o, e[0])
   endtask : st

   initial begin
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      rd_chk(MFTAM_OFS_CTRL, 32'h0);
      rd_chk(MFTAM_OFS_IRQ_MASK, 32'h0);
      rd_chk(MFTAM_OFS_CMD, 32'h0);
      wr_reg(8'h14, 32'hffffffff);
      rd_chk(8'h14, 32'h0);
      wr_reg(MFTAM_OFS_STATUS, 32'hffffffff);
      rd_chk(MFTAM_OFS_STATUS, 32'h0);
      wr_reg(MFTAM_OFS_CTRL, 32'hffffffff);
      rd_chk(MFTAM_OFS_CTRL, 32'h3f);
      wr_reg(MFTAM_OFS_CTRL, 32'h0);
      master_model_inst.image(1, 0, 1, 1);
      wt(3); st(11'h000, 1'b1);
      cz(7'h04); cz(7'h00); wt(3); st(11'h021, 1'b0);
      master_model_inst.image(1, 1, 1, 1);
      wt(3); st(11'h000, 1'b1);
      // held trip-reset must not acknowledge a later trip
      cz(7'h04); cz(7'h00); wt(4); st(11'h021, 1'b0);
      master_model_inst.image(1, 0, 1, 1);
      master_model_inst.image(1, 1, 1, 1);
      wt(3); st(11'h000, 1'b1);
      master_model_inst.image(1, 0, 1, 1);
      wr_reg(MFTAM_OFS_IRQ_MASK, 32'h0);
      rd_reg(MFTAM_OFS_IRQ_STAT, d);
      cz(7'h04); cz(7'h00); wt(3);
      `CHK(irq_o, 1'b0)
      wr_reg(MFTAM_OFS_IRQ_MASK, 32'h7ff);
      rd_chk(MFTAM_OFS_IRQ_MASK, 32'h7ff);
      `CHK(irq_o, 1'b1)
      rd_chk(MFTAM_OFS_IRQ_STAT, 32'h021);
      `CHK(irq_o, 1'b0)
      rd_chk(MFTAM_OFS_IRQ_STAT, 32'h0);
      wr_reg(MFTAM_OFS_CMD, 32'h1); wt(3); st(11'h000, 1'b1);
      cz(7'h40); cz(7'h00); wt(3); st(11'h005, 1'b0);
      master_model_inst.image(1, 1, 1, 1);
      wt(3); st(11'h005, 1'b0);
      master_model_inst.image(1, 0, 0, 1);
      wt(3); st(11'h205, 1'b0);
      master_model_inst.image(0, 0, 1, 1);
      wt(3); st(11'h000, 1'b0);
      master_model_inst.image(1, 0, 1, 1);
      cz(7'h10); wt(3); st(11'h011, 1'b0);
      cz(7'h00); wt(3); st(11'h000, 1'b1);
      cz(7'h08); wt(3); st(11'h001, 1'b0);
      cz(7'h00); wt(3); st(11'h000, 1'b1);
      cz(7'h02); wt(3); st(11'h082, 1'b1);
      cz(7'h00); wt(3); st(11'h000, 1'b1);
      cz(7'h01); wt(3); st(11'h102, 1'b1);
      cz(7'h00); wt(3); st(11'h000, 1'b1);
      wr_reg(MFTAM_OFS_CTRL, 32'h0c);
      cz(7'h02); wt(3); st(11'h0c1, 1'b0);
      master_model_inst.image(1, 1, 1, 1);
      wt(3); st(11'h0c1, 1'b0);
      cz(7'h00); wt(3); st(11'h0c1, 1'b0);
      master_model_inst.image(1, 0, 1, 1);
      master_model_inst.image(1, 1, 1, 1);
      wt(3); st(11'h000, 1'b1);
      master_model_inst.image(1, 0, 1, 1);
      wr_reg(MFTAM_OFS_CTRL, 32'h0d);
      cz(7'h01); wt(3); st(11'h141, 1'b0);
      cz(7'h00); wt(3); st(11'h000, 1'b1);
      wr_reg(MFTAM_OFS_CTRL, 32'h10);
      master_model_inst.image(1, 0, 0, 1);
      wt(3); st(11'h200, 1'b0);
      `CHK(bus_ind_o, 1'b1)
      master_model_inst.image(1, 0, 1, 1);
      wt(3); st(11'h000, 1'b1);
      wr_reg(MFTAM_OFS_CTRL, 32'h0);
      master_model_inst.image(1, 0, 0, 1);
      wt(3); st(11'h200, 1'b1);
      master_model_inst.image(1, 0, 1, 0);
      wt(3); st(11'h400, 1'b1);
      `CHK(bus_ind_o, 1'b0)
      master_model_inst.image(1, 0, 1, 1);
      wt(3); st(11'h000, 1'b1);
      wr_reg(MFTAM_OFS_CTRL, 32'h30);
      master_model_inst.image(0, 0, 1, 1);
      master_model_inst.image(0, 0, 1, 0);
      wt(3); st(11'h400, 1'b1);
      master_model_inst.image(1, 0, 1, 1);
      wr_reg(MFTAM_OFS_CTRL, 32'h02);
      cz(7'h04); cz(7'h00); wt(3); st(11'h021, 1'b1);
      master_model_inst.image(0, 0, 1, 1);
      wt(3); `CHK(sw_o, 1'b0)
      master_model_inst.image(1, 1, 1, 1);
      wt(3); st(11'h000, 1'b1);
      master_model_inst.image(1, 0, 1, 1);
      cz(7'h20); cz(7'h00); wt(3); st(11'h009, 1'b0);
      // only a reset clears a defect
      @(posedge clk_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      wt(3); st(11'h000, 1'b1);
      close_out();
   end
endmodule : testbench
